// *** src/scalar_exec_pkg.sv ***
// Shared constants and types for the scalar execution block
package scalar_exec_pkg;
	localparam logic [11:0] OFS_CTRL     = 12'h000;
	localparam logic [11:0] OFS_STATUS   = 12'h004;
	localparam logic [11:0] OFS_PC       = 12'h008;
	localparam logic [11:0] OFS_INBOUND  = 12'h00c;
	localparam logic [11:0] OFS_OUTBOUND = 12'h010;
	localparam logic [11:0] OFS_FLAGS    = 12'h014;
	localparam int CTRL_RUN_BIT      = 0;
	localparam int CTRL_RESTART_BIT  = 1;
	localparam int STAT_RUNNING      = 0;
	localparam int STAT_HALTED       = 1;
	localparam int STAT_OUT_NOT_EMPTY = 2;
	localparam int STAT_IN_NOT_FULL  = 3;
	localparam int STAT_STALL_OUT    = 4;
	localparam int STAT_STALL_IN     = 5;
	localparam int STAT_ELEM_BUSY    = 6;
	localparam logic [31:0] PC_RESET  = 32'h0000_0000;
	localparam logic [31:0] SHORT_LEN = 32'h0000_0004;
	localparam logic [31:0] LONG_LEN  = 32'h0000_0008;
	localparam logic [4:0]  LINK_REG  = 5'h1f;
	localparam logic [4:0]  SPEC_FLAGS = 5'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [5:0] {
		OP_MOV_RR, OP_MOV_TO_OUT, OP_MOV_FROM_IN, OP_MOV_IE, OP_MOV_IM, OP_MOV_SR, OP_MOV_RS,
		OP_LD_M, OP_LD_E, OP_ST_M, OP_ST_E, OP_LEA_IM, OP_LEA_IE,
		OP_ALU_RR, OP_ALU_IM, OP_ALU_IE,
		OP_JMP_R, OP_JMP_E, OP_JSR_R, OP_JSR_E, OP_BRA, OP_BSR, OP_BCC
	} opcode_t;

	typedef enum logic [3:0] {
		ALU_ADD, ALU_SUB, ALU_RSB, ALU_AND, ALU_OR, ALU_XOR,
		ALU_SHL, ALU_SHLA, ALU_SHRL, ALU_SHRA, ALU_CMP
	} alu_op_t;

	typedef enum logic [3:0] {
		COND_EQUAL, COND_NOT_EQUAL, COND_UNSIGNED_AT_LEAST, COND_UNSIGNED_BELOW,
		COND_UNSIGNED_ABOVE, COND_UNSIGNED_AT_MOST, COND_PLUS, COND_MINUS,
		COND_OVERFLOW_SET_TEST, COND_OVERFLOW_CLEAR_TEST, COND_SIGNED_AT_LEAST,
		COND_SIGNED_BELOW, COND_SIGNED_ABOVE, COND_SIGNED_AT_MOST
	} cond_t;

	typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_HALT} core_state_t;

	typedef enum logic [2:0] {
		SEL_CTRL, SEL_STATUS, SEL_PC, SEL_INBOUND, SEL_OUTBOUND, SEL_FLAGS, SEL_NONE
	} reg_sel_t;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} flags_t;

	typedef struct packed {
		opcode_t     op;
		logic [4:0]  dst;
		logic [4:0]  src;
		logic [15:0] imm;
	} instr_t;

	typedef struct packed {
		logic [31:0] val;
		flags_t      f;
	} alu_res_t;

	function automatic reg_sel_t reg_decode(input logic [11:0] a);
		unique case (a)
			OFS_CTRL:     return SEL_CTRL;
			OFS_STATUS:   return SEL_STATUS;
			OFS_PC:       return SEL_PC;
			OFS_INBOUND:  return SEL_INBOUND;
			OFS_OUTBOUND: return SEL_OUTBOUND;
			OFS_FLAGS:    return SEL_FLAGS;
			default:      return SEL_NONE;
		endcase
	endfunction : reg_decode
endpackage : scalar_exec_pkg

// *** src/cond_eval.sv ***
// Condition code evaluator used by the scalar execution unit
`timescale 1ns/1ps
`default_nettype none
module cond_eval
(
	input  wire scalar_exec_pkg::flags_t flags,
	input  wire scalar_exec_pkg::cond_t  code,
	output logic                         holds
);
	import scalar_exec_pkg::*;

	logic sgn_below;

	always_comb
	begin
		sgn_below = flags.n ^ flags.v; // RULE_02
		unique case (code)
			COND_EQUAL:               holds = flags.z; // RULE_01
			COND_NOT_EQUAL:           holds = !flags.z;
			COND_UNSIGNED_AT_LEAST:   holds = flags.c;
			COND_UNSIGNED_BELOW:      holds = !flags.c;
			COND_UNSIGNED_ABOVE:      holds = flags.c && !flags.z;
			COND_UNSIGNED_AT_MOST:    holds = !flags.c || flags.z;
			COND_PLUS:                holds = !flags.n;
			COND_MINUS:               holds = flags.n;
			COND_OVERFLOW_SET_TEST:   holds = flags.v;
			COND_OVERFLOW_CLEAR_TEST: holds = !flags.v;
			COND_SIGNED_AT_LEAST:     holds = !sgn_below; // RULE_02
			COND_SIGNED_BELOW:        holds = sgn_below;
			COND_SIGNED_ABOVE:        holds = !sgn_below && !flags.z;
			COND_SIGNED_AT_MOST:      holds = sgn_below || flags.z;
			default:                  holds = 1'b0;
		endcase
	end
endmodule : cond_eval
`default_nettype wire

// *** src/word_buffer.sv ***
// Small first-in first-out word buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_buffer
#(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 2
)(
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned PW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("buffer depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    rd_q;
	logic [PW:0]      count_q;
	logic             push;
	logic             pop;
	logic [PW-1:0]    wr_idx;

	assign in_ready  = count_q != DEPTH[PW:0];
	assign out_valid = count_q != '0;
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign wr_idx    = rd_q + count_q[PW-1:0];

	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_idx] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rd_q    <= '0;
			count_q <= '0;
		end
		else
		begin
			if (pop)
				rd_q <= rd_q + 1'b1;
			count_q <= count_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		end
	end
endmodule : word_buffer
`default_nettype wire

// *** src/scalar_exec_unit.sv ***
// Scalar execution unit of the array control unit with host queues
// Contract
// RULE_01: Fourteen condition codes built from zero, carry, negative and overflow flags.
// RULE_02: Signed tests use negative xor overflow, greater and at-most add zero.
// RULE_03: Move to outbound queue deposits when room, else stalls execution.
// RULE_04: Host reads outbound queue words, freeing room so a stalled unit resumes.
// RULE_05: Move from inbound queue takes the oldest word, strict first-in first-out.
// RULE_06: Empty inbound queue stalls execution until the host writes a word.
// RULE_07: Pending element memory operations keep running during a queue stall.
// RULE_08: Moves carry 32-bit values among registers, specials, immediates and queues.
// RULE_09: Loads and stores reach control memory; address compute adds immediate.
// RULE_10: ALU adds, subtracts, logic, shifts; arithmetic right fills with carry.
// RULE_11: Compare computes source minus destination for flags only, no write.
// RULE_12: Absolute call at N stores N plus 8 in the link register.
// RULE_13: Relative subroutine branch at N stores N plus 4 in link register.
// RULE_14: Return is an absolute jump through the link register.
// RULE_15: Branch word offsets count from the next instruction; zero falls through.
// RULE_16: Absolute jump and call targets are byte addresses loaded into PC.
// RULE_17: Conditional branch adds word offset when condition holds; minus one loops.
// RULE_18: Host sees outbound not-empty and inbound not-full indications.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module scalar_exec_unit
#(
	parameter int unsigned CONTROL_MEMORY_WORDS     = 64,
	parameter int unsigned QUEUE_DEPTH    = 2,
	parameter int unsigned ELEM_OP_CYCLES = 4
)(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             fetch_req,
	output logic [31:0]      fetch_addr,
	input  wire logic        fetch_valid,
	input  wire logic [31:0] fetch_word,
	input  wire logic [31:0] fetch_ext,
	input  wire logic        elem_op_start,
	output logic             elem_busy
);
	import scalar_exec_pkg::*;

	localparam int unsigned CAW = $clog2(CONTROL_MEMORY_WORDS);

	if (CONTROL_MEMORY_WORDS < 2 || (CONTROL_MEMORY_WORDS & (CONTROL_MEMORY_WORDS - 1)) != 0 || ELEM_OP_CYCLES == 0)
	begin : g_bad_param
		$error("control memory depth must be a power of two, element latency nonzero");
	end

	// Register file, control memory and core state
	logic [31:0]  regs_q [32];
	logic [31:0]  control_memory_q [CONTROL_MEMORY_WORDS];
	logic [31:0]  pc_q;
	flags_t       flags_q;
	core_state_t  state_q;
	core_state_t  state_d;
	logic         fetch_req_q;
	logic [15:0]  elem_rem_q;
	logic [15:0]  elem_rem_d;
	logic         elem_busy_q;

	// Bus slave state
	logic         awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic         aw_have_q, w_have_q;
	logic [11:0]  awaddr_q;
	logic [31:0]  wdata_q;
	logic [3:0]   wstrb_q;
	logic [1:0]   bresp_q, rresp_q;
	logic [31:0]  rdata_q;
	logic         write_fire, ar_fire, ctrl_wr;
	reg_sel_t     wsel, rsel;
	logic [31:0]  rd_val;
	logic         rd_err;

	// Queue wiring
	logic         ib_push, ib_in_ready, ib_out_valid, ib_pop;
	logic         ob_push, ob_in_ready, ob_out_valid, ob_pop;
	logic [31:0]  ib_data, ob_data;

	// Decode and execute
	instr_t       ins;
	logic [31:0]  rs, rd, sext16, len, seq_pc, b_opnd;
	logic         wb_en, flags_we, want_push, want_pop, cm_we, illegal, cond_ok;
	logic         stall_out, stall_in, fire;
	logic [4:0]   wb_idx;
	logic [31:0]  wb_val, pc_next, cm_addr;
	flags_t       flags_d;
	alu_op_t      aop;
	alu_res_t     ar;

	function automatic alu_res_t alu_exec(alu_op_t op, logic [31:0] a, logic [31:0] b,
			flags_t f);
		alu_res_t    r;
		logic [32:0] t;
		r = '{val: 32'h0, f: f};
		t = 33'h0;
		unique case (op)
			ALU_ADD:
			begin
				t = {1'b0, a} + {1'b0, b};
				r.f.c = t[32];
				r.f.v = (a[31] == b[31]) && (t[31] != a[31]);
			end
			ALU_SUB:
			begin
				t = {1'b0, a} - {1'b0, b};
				r.f.c = !t[32];
				r.f.v = (a[31] != b[31]) && (t[31] != a[31]);
			end
			ALU_RSB, ALU_CMP:
			begin
				t = {1'b0, b} - {1'b0, a}; // RULE_11
				r.f.c = !t[32];
				r.f.v = (a[31] != b[31]) && (t[31] != b[31]);
			end
			ALU_AND:  t = {1'b0, a & b};
			ALU_OR:   t = {1'b0, a | b};
			ALU_XOR:  t = {1'b0, a ^ b};
			ALU_SHL, ALU_SHLA: t = {1'b0, a << b[4:0]};
			ALU_SHRL: t = {1'b0, a >> b[4:0]}; // RULE_10
			ALU_SHRA: t = {1'b0, (a >> b[4:0]) | ({32{f.c}} & ~(32'hffff_ffff >> b[4:0]))};
			default:  t = 33'h0;
		endcase
		r.val = t[31:0];
		r.f.n = t[31];
		r.f.z = t[31:0] == 32'h0;
		return r;
	endfunction : alu_exec

	function automatic logic is_long(opcode_t op);
		return op inside {OP_MOV_IE, OP_LD_E, OP_ST_E, OP_LEA_IE, OP_ALU_IE,
			OP_JMP_R, OP_JMP_E, OP_JSR_R, OP_JSR_E};
	endfunction : is_long

	cond_eval u_cond (
		.flags (flags_q),
		.code  (cond_t'(ins.dst[3:0])),
		.holds (cond_ok)
	);

	word_buffer #(.WIDTH(32), .DEPTH(QUEUE_DEPTH)) u_inbound_host_queue (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (ib_push),
		.in_ready  (ib_in_ready),
		.in_data   (wdata_q),
		.out_valid (ib_out_valid),
		.out_ready (ib_pop),
		.out_data  (ib_data)
	);

	word_buffer #(.WIDTH(32), .DEPTH(QUEUE_DEPTH)) u_outbound_host_queue (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (ob_push),
		.in_ready  (ob_in_ready),
		.in_data   (rs),
		.out_valid (ob_out_valid),
		.out_ready (ob_pop),
		.out_data  (ob_data)
	);

	always_comb
	begin
		ins       = instr_t'(fetch_word);
		rs        = regs_q[ins.src];
		rd        = regs_q[ins.dst];
		sext16    = {{16{ins.imm[15]}}, ins.imm};
		len       = is_long(ins.op) ? LONG_LEN : SHORT_LEN;
		seq_pc    = pc_q + len;
		aop       = alu_op_t'(ins.imm[15:12]);
		b_opnd    = (ins.op == OP_ALU_IE) ? fetch_ext
			: (ins.op == OP_ALU_IM) ? {{20{ins.imm[11]}}, ins.imm[11:0]} : rs;
		ar        = alu_exec(aop, rd, b_opnd, flags_q);
		wb_en     = 1'b0;
		wb_idx    = ins.dst;
		wb_val    = 32'h0;
		flags_we  = 1'b0;
		flags_d   = ar.f;
		pc_next   = seq_pc;
		want_push = 1'b0;
		want_pop  = 1'b0;
		cm_we     = 1'b0;
		cm_addr   = fetch_ext;
		illegal   = 1'b0;
		unique case (ins.op)
			OP_MOV_RR:      begin wb_en = 1'b1; wb_val = rs; end // RULE_08
			OP_MOV_TO_OUT:  want_push = 1'b1;
			OP_MOV_FROM_IN: begin want_pop = 1'b1; wb_en = 1'b1; wb_val = ib_data; end // RULE_05
			OP_MOV_IE:      begin wb_en = 1'b1; wb_val = fetch_ext; end
			OP_MOV_IM:      begin wb_en = 1'b1; wb_val = sext16; end
			OP_MOV_SR:      begin wb_en = 1'b1; wb_val = (ins.src == SPEC_FLAGS) ? {28'h0, flags_q} : 32'h0; end
			OP_MOV_RS:
			begin
				flags_we = ins.dst == SPEC_FLAGS;
				flags_d  = flags_t'(rs[3:0]);
			end
			OP_LD_M:        begin wb_en = 1'b1; cm_addr = rs + sext16; end // RULE_09
			OP_LD_E:        wb_en = 1'b1;
			OP_ST_M:        begin cm_we = 1'b1; cm_addr = rd + sext16; end
			OP_ST_E:        cm_we = 1'b1;
			OP_LEA_IM:      begin wb_en = 1'b1; wb_val = rs + sext16; end
			OP_LEA_IE:      begin wb_en = 1'b1; wb_val = rs + fetch_ext; end
			OP_ALU_RR, OP_ALU_IM, OP_ALU_IE:
			begin
				// Shifts with a long immediate and unknown operations halt the core
				illegal  = (ins.imm[15:12] > ALU_CMP) || (ins.op == OP_ALU_IE &&
					aop inside {ALU_SHL, ALU_SHLA, ALU_SHRL, ALU_SHRA}); // RULE_10
				flags_we = 1'b1;
				wb_en    = aop != ALU_CMP; // RULE_11
				wb_val   = ar.val;
			end
			OP_JMP_R:       pc_next = rs; // RULE_14
			OP_JMP_E:       pc_next = fetch_ext; // RULE_16
			OP_JSR_R, OP_JSR_E:
			begin
				wb_en   = 1'b1;
				wb_idx  = LINK_REG;
				wb_val  = seq_pc; // RULE_12
				pc_next = (ins.op == OP_JSR_R) ? rs : fetch_ext;
			end
			OP_BRA:         pc_next = seq_pc + {sext16[29:0], 2'b00}; // RULE_15
			OP_BSR:
			begin
				wb_en   = 1'b1;
				wb_idx  = LINK_REG;
				wb_val  = seq_pc; // RULE_13
				pc_next = seq_pc + {sext16[29:0], 2'b00};
			end
			OP_BCC:
			begin
				illegal = ins.dst[3:0] > COND_SIGNED_AT_MOST;
				if (cond_ok)
					pc_next = seq_pc + {sext16[29:0], 2'b00}; // RULE_17
			end
			default:        illegal = 1'b1;
		endcase
		if (ins.op inside {OP_LD_M, OP_LD_E})
			wb_val = control_memory_q[cm_addr[CAW+1:2]];
	end

	assign stall_out = want_push && !ob_in_ready; // RULE_03
	assign stall_in  = want_pop && !ib_out_valid; // RULE_06
	assign fire      = state_q == ST_RUN && fetch_valid && !illegal && !stall_out && !stall_in;
	assign ob_push   = fire && want_push;
	assign ib_pop    = fire && want_pop;

	always_ff @(posedge clk)
	begin
		if (!resetn)
			for (int i = 0; i < 32; i++)
				regs_q[i] <= 32'h0;
		else if (fire && wb_en)
			regs_q[wb_idx] <= wb_val;
	end

	always_ff @(posedge clk)
	begin
		if (fire && cm_we)
			control_memory_q[cm_addr[CAW+1:2]] <= rs;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			flags_q <= '0;
		else if (fire && flags_we)
			flags_q <= flags_d;
	end

	always_comb
	begin
		state_d = state_q;
		if (ctrl_wr && wdata_q[CTRL_RESTART_BIT])
			state_d = wdata_q[CTRL_RUN_BIT] ? ST_RUN : ST_STOP;
		else if (ctrl_wr && state_q != ST_HALT)
			state_d = wdata_q[CTRL_RUN_BIT] ? ST_RUN : ST_STOP;
		else if (state_q == ST_RUN && fetch_valid && illegal)
			state_d = ST_HALT;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_q     <= ST_STOP;
			fetch_req_q <= 1'b0;
			pc_q        <= PC_RESET;
		end
		else
		begin
			state_q     <= state_d;
			fetch_req_q <= state_d == ST_RUN;
			if (ctrl_wr && wdata_q[CTRL_RESTART_BIT])
				pc_q <= PC_RESET;
			else if (fire)
				pc_q <= pc_next;
		end
	end

	// Element memory work drains on its own, whatever the scalar core is doing
	always_comb
	begin
		elem_rem_d = elem_rem_q - {15'h0, elem_rem_q != 16'h0}
			+ (elem_op_start ? ELEM_OP_CYCLES[15:0] : 16'h0); // RULE_07
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			elem_rem_q  <= 16'h0;
			elem_busy_q <= 1'b0;
		end
		else
		begin
			elem_rem_q  <= elem_rem_d;
			elem_busy_q <= elem_rem_d != 16'h0;
		end
	end

	// Bus write path: address and data may arrive in either order
	assign wsel       = reg_decode(awaddr_q);
	assign write_fire = aw_have_q && w_have_q && !bvalid_q;
	assign ctrl_wr    = write_fire && wsel == SEL_CTRL && wstrb_q[0];
	assign ib_push    = write_fire && wsel == SEL_INBOUND && ib_in_ready;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			aw_have_q <= 1'b0;
			awready_q <= 1'b0;
			awaddr_q  <= 12'h000;
		end
		else if (s_axi_awvalid && awready_q)
		begin
			aw_have_q <= 1'b1;
			awready_q <= 1'b0;
			awaddr_q  <= s_axi_awaddr;
		end
		else if (write_fire || !aw_have_q)
		begin
			aw_have_q <= 1'b0;
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			w_have_q <= 1'b0;
			wready_q <= 1'b0;
			wdata_q  <= 32'h0;
			wstrb_q  <= 4'h0;
		end
		else if (s_axi_wvalid && wready_q)
		begin
			w_have_q <= 1'b1;
			wready_q <= 1'b0;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end
		else if (write_fire || !w_have_q)
		begin
			w_have_q <= 1'b0;
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end
		else if (write_fire)
		begin
			bvalid_q <= 1'b1;
			// A push into a full inbound queue is refused, not held
			bresp_q  <= (wsel == SEL_NONE || (wsel == SEL_INBOUND && !ib_in_ready))
				? RESP_SLVERR : RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// Bus read path: outbound queue pops on the address handshake
	assign rsel    = reg_decode(s_axi_araddr);
	assign ar_fire = s_axi_arvalid && arready_q;
	assign ob_pop  = ar_fire && rsel == SEL_OUTBOUND && ob_out_valid; // RULE_04

	always_comb
	begin
		rd_val = 32'h0;
		rd_err = 1'b0;
		unique case (rsel)
			SEL_CTRL:     rd_val[CTRL_RUN_BIT] = state_q == ST_RUN;
			SEL_STATUS:
			begin
				rd_val[STAT_RUNNING]       = state_q == ST_RUN;
				rd_val[STAT_HALTED]        = state_q == ST_HALT;
				rd_val[STAT_OUT_NOT_EMPTY] = ob_out_valid; // RULE_18
				rd_val[STAT_IN_NOT_FULL]   = ib_in_ready;
				rd_val[STAT_STALL_OUT]     = state_q == ST_RUN && fetch_valid && stall_out;
				rd_val[STAT_STALL_IN]      = state_q == ST_RUN && fetch_valid && stall_in;
				rd_val[STAT_ELEM_BUSY]     = elem_busy_q;
			end
			SEL_PC:       rd_val = pc_q;
			SEL_INBOUND:  rd_val = 32'h0;
			SEL_OUTBOUND: begin rd_val = ob_data; rd_err = !ob_out_valid; end
			SEL_FLAGS:    rd_val = {28'h0, flags_q};
			default:      rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= RESP_OKAY;
		end
		else if (ar_fire)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_err ? 32'h0 : rd_val;
			rresp_q   <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		else if (rvalid_q && s_axi_rready)
		begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
		else if (!rvalid_q)
			arready_q <= 1'b1;
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign fetch_req     = fetch_req_q;
	assign fetch_addr    = pc_q;
	assign elem_busy     = elem_busy_q;

	AST_OUT_STALL: assert property (@(posedge clk) disable iff (!resetn) // RULE_03
		stall_out && !ctrl_wr |=> pc_q == $past(pc_q))
		else $error("pc moved while outbound queue full");
	AST_IN_STALL: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
		stall_in && !ctrl_wr |=> $stable(pc_q) && regs_q[$past(ins.dst)] == $past(rd))
		else $error("execution passed an empty inbound queue");
	AST_IN_DATA: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
		ib_pop |=> regs_q[$past(ins.dst)] == $past(ib_data))
		else $error("inbound word not delivered to destination");
	AST_ELEM_RUN: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
		(stall_in || stall_out) && elem_rem_q != 16'h0 && !elem_op_start
		|=> elem_rem_q == $past(elem_rem_q) - 16'h1)
		else $error("element work halted during queue stall");
	AST_CMP_NOWRITE: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
		fire && ins.op inside {OP_ALU_RR, OP_ALU_IM} && aop == ALU_CMP
		|=> regs_q[$past(ins.dst)] == $past(rd))
		else $error("compare wrote its destination");
	AST_CALL_LINK: assert property (@(posedge clk) disable iff (!resetn) // RULE_12
		fire && ins.op == OP_JSR_E
		|=> regs_q[31] == $past(pc_q) + 32'h8 && pc_q == $past(fetch_ext))
		else $error("absolute call link or target wrong");
	AST_BSR_LINK: assert property (@(posedge clk) disable iff (!resetn) // RULE_13
		fire && ins.op == OP_BSR |=> regs_q[31] == $past(pc_q) + 32'h4)
		else $error("relative call link wrong");
	AST_BRA_ZERO: assert property (@(posedge clk) disable iff (!resetn) // RULE_15
		fire && ins.op == OP_BRA && ins.imm == 16'h0 |=> pc_q == $past(pc_q) + 32'h4)
		else $error("zero branch offset did not fall through");
	AST_BCC_LOOP: assert property (@(posedge clk) disable iff (!resetn) // RULE_17
		fire && ins.op == OP_BCC && cond_ok && ins.imm == 16'hffff |=> $stable(pc_q))
		else $error("taken branch with offset minus one did not loop");
	AST_SIGNED_BELOW: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
		ins.dst[3:0] == 4'hb |-> cond_ok == (flags_q.n != flags_q.v))
		else $error("signed below evaluated wrongly");
endmodule : scalar_exec_unit
`default_nettype wire

// *** test/fetch_model.sv ***
// Program memory model answering the instruction fetch port
`timescale 1ns/1ps
`default_nettype none
module fetch_model
(
	input  wire logic        fetch_req,
	input  wire logic [31:0] fetch_addr,
	output logic             fetch_valid,
	output logic [31:0]      fetch_word,
	output logic [31:0]      fetch_ext
);
	// Answers at once; unknown places hold a jump to themselves
	assign fetch_valid = fetch_req;
	assign fetch_ext = (fetch_addr == 32'h18) ? 32'h20 : fetch_addr;
	always_comb
	begin
		case (fetch_addr)
			32'h00: fetch_word = 32'h10200005;
			32'h04: fetch_word = 32'h04010000;
			32'h08: fetch_word = 32'h08400000;
			32'h0c: fetch_word = 32'h04020000;
			32'h10: fetch_word = 32'h54000000;
			32'h14: fetch_word = 32'h041f0000;
			32'h18: fetch_word = 32'h4c000000;
			32'h20: fetch_word = 32'h041f0000;
			// Signed-below branch skips a push; carry then fills the right shift
			32'h24: fetch_word = 32'h11600003;
			32'h28: fetch_word = 32'h3960afff;
			32'h2c: fetch_word = 32'h59600001;
			32'h30: fetch_word = 32'h040b0000;
			32'h34: fetch_word = 32'h39609001;
			32'h38: fetch_word = 32'h2ca00010;
			32'h3c: fetch_word = 32'h24ab0000;
			32'h40: fetch_word = 32'h54000003;
			32'h44: fetch_word = 32'h1c800010;
			32'h48: fetch_word = 32'h04040000;
			32'h4c: fetch_word = 32'h50000003;
			32'h50: fetch_word = 32'h50000000;
			32'h54: fetch_word = 32'h401f0000;
			32'h5c: fetch_word = 32'h5820ffff;
			default: fetch_word = 32'h44000000;
		endcase
	end
endmodule : fetch_model
`default_nettype wire

// *** test/test_scalar_exec_unit.sv ***
// Bench running a short program against the host queues and status
`timescale 1ns/1ps
`default_nettype none
module test_scalar_exec_unit;
	import scalar_exec_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, elem_op_start = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rd_val, fetch_addr, fetch_word, fetch_ext;
	logic awready, wready, bvalid, arready, rvalid, fetch_req, fetch_valid, elem_busy;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [31:0] exp_out [5] = '{32'h5, 32'ha5a50001, 32'h14, 32'h20, 32'h80000001};
	int bad_count = 0, checks = 0, cyc = 0;
	always #25 clk = ~clk;
	scalar_exec_unit #(.ELEM_OP_CYCLES(40)) uut (.clk(clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_ext(fetch_ext),
		.elem_op_start(elem_op_start), .elem_busy(elem_busy));
	fetch_model mem (.fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_ext(fetch_ext));
	task automatic give_verdict;
		$display("mismatches %0d of %0d comparisons", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks++;
		if (got !== want)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Loop test sees the flags only after the first edge
		do
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready)
			begin
				chk({30'h0, bresp}, {30'h0, er});
				bready <= 1'b0;
			end
		end
		while (awvalid || wvalid || bready);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		d = 32'h0;
		do
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready)
			begin
				d = rdata;
				chk({30'h0, rresp}, {30'h0, er});
				rready <= 1'b0;
			end
		end
		while (arvalid || rready);
	endtask : rd
	// Hang guard well above the few hundred cycles the program needs
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		rd(12'h040, RESP_SLVERR, rd_val);
		chk(rd_val, 32'h0);
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		repeat (20) @(posedge clk);
		rd(OFS_STATUS, RESP_OKAY, rd_val);
		chk(rd_val & 32'h34, 32'h24);
		rd(OFS_PC, RESP_OKAY, rd_val);
		chk(rd_val, 32'h8);
		elem_op_start <= 1'b1;
		@(posedge clk);
		elem_op_start <= 1'b0;
		rd(OFS_STATUS, RESP_OKAY, rd_val);
		chk(rd_val & 32'h40, 32'h40);
		wr(OFS_INBOUND, 32'ha5a50001, RESP_OKAY);
		repeat (20) @(posedge clk);
		rd(OFS_STATUS, RESP_OKAY, rd_val);
		chk(rd_val & 32'h3c, 32'h1c);
		rd(OFS_PC, RESP_OKAY, rd_val);
		chk(rd_val, 32'h14);
		for (int i = 0; i < 5; i++)
		begin
			rd(OFS_OUTBOUND, RESP_OKAY, rd_val);
			chk(rd_val, exp_out[i]);
			repeat (20) @(posedge clk);
		end
		rd(OFS_OUTBOUND, RESP_SLVERR, rd_val);
		chk(rd_val, 32'h0);
		rd(OFS_FLAGS, RESP_OKAY, rd_val);
		chk(rd_val, 32'ha);
		rd(OFS_PC, RESP_OKAY, rd_val);
		chk(rd_val, 32'h5c);
		give_verdict();
	end
endmodule : test_scalar_exec_unit
`default_nettype wire
